// ### hdl/cmd_decoder_defs.vh
// Constants for the command message decoder
`ifndef CMD_DECODER_DEFS_VH
`define CMD_DECODER_DEFS_VH
// Register offsets (word addresses on the plain port)
`define REG_STOP 4'h0
`define REG_SEL 4'h1
`define REG_SPEED 4'h2
`define REG_STATUS 4'h3
`define REG_MASK 4'h4
`define REG_CTRL 4'h5
// Stop field in byte 1, bits 1..2 (lsb-first bit numbering)
`define STOP_LSB 0
`define STOP_RUN 2'h0
`define STOP_REQ 2'h1
// Speed selection flags in byte 1, bits 1..5
`define SEL_WIDTH 5
`define SEL_RESET 5'h00
// Speed-up command, bytes 2..3, little endian
`define SPEED_RESET 16'h0000
`define SPEED_ERR_HI 8'hfe
`define SPEED_NA_HI 8'hff
// Status bits
`define ST_STOP 0
`define ST_SEL 1
`define ST_SPEED 2
`define ST_ERRCLR 3
`endif

// ### hdl/frame_field_pick.v
// Field extraction from a received eight-byte payload
`timescale 1ns/10ps
module frame_field_pick
(
  input wire [63:0] payload,
  output wire [1:0] stopCode,
  output wire [4:0] selFlags,
  output wire [15:0] speedRaw,
  output wire speedValid
);
  `include "cmd_decoder_defs.vh"
  // ****************************************
  // Field slices
  // ****************************************
  assign stopCode = payload[`STOP_LSB+1:`STOP_LSB];
  assign selFlags = payload[4:0];
  assign speedRaw = payload[23:8];
  // Error and not-available high bytes are invalid
  assign speedValid = (payload[23:16] != `SPEED_ERR_HI) &&
    (payload[23:16] != `SPEED_NA_HI);
endmodule // frame_field_pick

// ### hdl/can_stop_speed_cmd_decoder.v
// Decoder for engine-halt and speed-choice command messages
// Behaviour
// - Halt message bits 1-2 of byte 1: 00 run, 01 halt requested.
// - Halt codes 10 and 11 are ignored and leave the state alone.
// - Halt message is event driven; absence never counts as error.
// - Speed message byte 1 bits 1-5: choice1, choice2, up, down, enable.
// - After reset all five flags OFF until a valid message arrives.
// - During reception error the last valid flags are held.
// - After the error clears, new messages are applied again.
// - Speed-up is U16 from byte 2, 0.125 rpm/count, reset 0, held.
`timescale 1ns/10ps
module can_stop_speed_cmd_decoder
(
  input wire clk,
  input wire reset,
  input wire clkEn,
  input wire rxValid,
  input wire rxIsHalt,
  input wire rxIsSpeed,
  input wire [63:0] rxPayload,
  input wire rxError,
  input wire [3:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdData,
  output reg haltRequest,
  output reg speedChoiceOne,
  output reg speedChoiceTwo,
  output reg workMachineUp,
  output reg workMachineDown,
  output reg speedChoiceEnable,
  output reg [15:0] speedUpCmd,
  output reg irq
);
  `include "cmd_decoder_defs.vh"
  wire [1:0] stopCode;
  wire [4:0] selFlags;
  wire [15:0] speedRaw;
  wire speedValid;
  reg [3:0] status_q;
  reg [3:0] mask_q;
  reg errPrev_q;
  reg useErr_q;
  reg [3:0] evt;
  reg [31:0] rdMux;
  reg takeHalt;
  reg takeSpeed;
  // ****************************************
  // Payload fields
  // ****************************************
  frame_field_pick i_frame_field_pick
  (
    .payload(rxPayload),
    .stopCode(stopCode),
    .selFlags(selFlags),
    .speedRaw(speedRaw),
    .speedValid(speedValid)
  );
  // ****************************************
  // Acceptance
  // ****************************************
  always @*
  begin
    // Halt frames never depend on the error flag
    takeHalt = rxValid && rxIsHalt &&
      (stopCode == `STOP_RUN || stopCode == `STOP_REQ);
    // Speed frames are refused while an error stands
    takeSpeed = rxValid && rxIsSpeed &&
      !(rxError && useErr_q);
    evt = 4'h0;
    evt[`ST_STOP] = takeHalt;
    evt[`ST_SEL] = takeSpeed;
    evt[`ST_SPEED] = takeSpeed && speedValid;
    evt[`ST_ERRCLR] = errPrev_q && !rxError;
  end
  // ****************************************
  // Decoded outputs
  // ****************************************
  always @(posedge clk)
  begin
    if (reset)
    begin
      haltRequest <= 1'b0;
      speedChoiceOne <= 1'b0;
      speedChoiceTwo <= 1'b0;
      workMachineUp <= 1'b0;
      workMachineDown <= 1'b0;
      speedChoiceEnable <= 1'b0;
      speedUpCmd <= `SPEED_RESET;
      errPrev_q <= 1'b0;
    end
    else if (clkEn)
    begin
      errPrev_q <= rxError;
      if (takeHalt)
        haltRequest <= (stopCode == `STOP_REQ);
      if (takeSpeed)
      begin
        // Bits 6-8 of byte 1 are not looked at
        speedChoiceOne <= selFlags[0];
        speedChoiceTwo <= selFlags[1];
        workMachineUp <= selFlags[2];
        workMachineDown <= selFlags[3];
        speedChoiceEnable <= selFlags[4];
        if (speedValid)
          speedUpCmd <= speedRaw;
      end
    end
  end
  // ****************************************
  // Register port
  // ****************************************
  always @*
  begin
    rdMux = 32'h00000000;
    case (regAddr)
      `REG_STOP: rdMux[0] = haltRequest;
      `REG_SEL: rdMux[4:0] = {speedChoiceEnable, workMachineDown,
        workMachineUp, speedChoiceTwo, speedChoiceOne};
      `REG_SPEED: rdMux[15:0] = speedUpCmd;
      `REG_STATUS: rdMux[3:0] = status_q;
      `REG_MASK: rdMux[3:0] = mask_q;
      `REG_CTRL: rdMux[1:0] = {rxError, useErr_q};
      default: rdMux = 32'h00000000;
    endcase
  end
  always @(posedge clk)
  begin
    if (reset)
    begin
      regRdData <= 32'h00000000;
      status_q <= 4'h0;
      mask_q <= 4'h0;
      useErr_q <= 1'b1;
      irq <= 1'b0;
    end
    else if (clkEn)
    begin
      regRdData <= regRd ? rdMux : 32'h00000000;
      if (regWr && regAddr == `REG_MASK)
        mask_q <= regWrData[3:0];
      if (regWr && regAddr == `REG_CTRL)
        useErr_q <= regWrData[0];
      // Set wins over write-one-to-clear
      if (regWr && regAddr == `REG_STATUS)
        status_q <= (status_q & ~regWrData[3:0]) | evt;
      else
        status_q <= status_q | evt;
      irq <= |(((status_q & ~((regWr && regAddr == `REG_STATUS) ?
        regWrData[3:0] : 4'h0)) | evt) & mask_q);
    end
  end
endmodule // can_stop_speed_cmd_decoder

// ### tb/cmd_decoder_assertions.sv
// Port checker for the command decoder
`timescale 1ns/10ps
module cmd_decoder_assertions
(
  input wire clk,
  input wire reset,
  input wire clkEn,
  input wire rxValid,
  input wire rxIsHalt,
  input wire rxIsSpeed,
  input wire [63:0] rxPayload,
  input wire rxError,
  input wire haltRequest,
  input wire speedChoiceEnable,
  input wire [15:0] speedUpCmd
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire h = clkEn && rxValid && rxIsHalt;
  wire s = clkEn && rxValid && rxIsSpeed;
  wire [23:0] p = rxPayload[23:0];
  halt_run_a: assert property (h && p[1:0] == 2'h0 |=> !haltRequest)
    else $error("halt run");
  halt_req_a: assert property (h && p[1:0] == 2'h1 |=> haltRequest)
    else $error("halt req");
  halt_keep_a: assert property (h && p[1] |=> $stable(haltRequest))
    else $error("halt keep");
  flag_take_a: assert property (s && !rxError |=>
    speedChoiceEnable == $past(p[4])) else $error("flag take");
  err_hold_a: assert property (rxError |=> $stable(speedUpCmd) &&
    $stable(speedChoiceEnable)) else $error("error hold");
  speed_take_a: assert property (s && !rxError &&
    p[23:17] != 7'h7f |=> speedUpCmd == $past(p[23:8]))
    else $error("speed take");
  speed_bad_a: assert property (s && p[23:17] == 7'h7f |=>
    $stable(speedUpCmd)) else $error("speed bad");
  reset_off_a: assert property ($fell(reset) |->
    speedUpCmd == 16'h0 && !speedChoiceEnable) else $error("reset off");
  cover property (s && !rxError);
  cover property (h && p[1]);
  cover property ($fell(rxError));
endmodule // cmd_decoder_assertions
bind can_stop_speed_cmd_decoder cmd_decoder_assertions
  i_cmd_decoder_assertions (.*);

// ### tb/machine_ctrl_model.sv
// Machine controller sending command frames
`timescale 1ns/10ps
module machine_ctrl_model
(
  input wire clk,
  output reg rxValid = 0,
  output reg rxIsHalt = 0,
  output reg rxIsSpeed = 0,
  output reg [63:0] rxPayload = 0
);
  task send(input h, input [63:0] d);
    rxValid <= 1;
    rxIsHalt <= h;
    rxIsSpeed <= !h;
    rxPayload <= d;
    @(posedge clk) rxValid <= 0;
    rxPayload <= ~d;
    repeat (2) @(posedge clk);
  endtask
endmodule // machine_ctrl_model

// ### tb/can_stop_speed_cmd_decoder_tb_top.sv
// Testbench for the command decoder
`timescale 1ns/10ps
`include "cmd_decoder_defs.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin nFail++; \
  $display("unexpected %0t %h %h", $time, a, b); end end
module can_stop_speed_cmd_decoder_tb_top;
  reg clk = 0, reset = 1, clkEn = 1, rxError = 1, regWr = 0, regRd = 0;
  reg [3:0] regAddr = 0;
  reg [31:0] regWrData = 0;
  wire rxValid, rxIsHalt, rxIsSpeed, haltRequest, speedChoiceOne, irq;
  wire speedChoiceTwo, workMachineUp, workMachineDown, speedChoiceEnable;
  wire [63:0] rxPayload;
  wire [31:0] regRdData;
  wire [15:0] speedUpCmd;
  wire [4:0] f = {speedChoiceEnable, workMachineDown, workMachineUp,
    speedChoiceTwo, speedChoiceOne};
  int nFail = 0, checks = 0;
  reg [1:0] c [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
  machine_ctrl_model i_machine_ctrl_model (.*);
  can_stop_speed_cmd_decoder i_can_stop_speed_cmd_decoder (.*);
  always #2.5 clk = ~clk;
  task wr(input [3:0] a, input [31:0] d);
    regWr <= 1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk) regWr <= 0;
    repeat (2) @(posedge clk);
  endtask
  task rd(input [3:0] a, input [31:0] e);
    regRd <= 1;
    regAddr <= a;
    @(posedge clk) regRd <= 0;
    #1 `CHK(regRdData, e)
    @(posedge clk);
  endtask
  task s(input [63:0] d, input [4:0] ef, input [15:0] es);
    i_machine_ctrl_model.send(0, d);
    `CHK(f, ef)
    `CHK(speedUpCmd, es)
  endtask
  task results;
    if (nFail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    s(64'h12_34ff, 5'h00, 16'h0);
    for (int i = 0; i < 4; i++)
    begin
      i_machine_ctrl_model.send(1, {56'h5a, 6'h2a, c[i]});
      `CHK(haltRequest, i < 2)
    end
    rxError <= 0;
    wr(`REG_STATUS, 32'hf);
    wr(`REG_MASK, 32'h4);
    s(64'h12_34f5, 5'h15, 16'h1234);
    `CHK(irq, 1'b1)
    rd(`REG_SPEED, 32'h1234);
    s(64'hfe_990a, 5'h0a, 16'h1234);
    wr(`REG_MASK, 32'h0);
    `CHK(irq, 1'b0)
    wr(`REG_MASK, 32'h4);
    `CHK(irq, 1'b1)
    wr(`REG_STATUS, 32'h4);
    `CHK(irq, 1'b0)
    rxError <= 1;
    s(64'h00_071f, 5'h0a, 16'h1234);
    rxError <= 0;
    s(64'h00_071f, 5'h1f, 16'h0007);
    clkEn <= 0;
    s(64'h0, 5'h1f, 16'h0007);
    clkEn <= 1;
    rd(`REG_STATUS, 32'he);
    rd(`REG_SEL, 32'h1f);
    rd(4'hf, 32'h0);
    results;
  end
  initial
  begin
    #20000;
    nFail++;
    results;
  end
endmodule // can_stop_speed_cmd_decoder_tb_top
